/* src/sensor_mode_config_regs.sv */
// Purpose: Two configuration registers and the conversion sequencer that they steer.
// Assumes: The bus engine runs on link_clk; the datapath and pin logic run on clk.
// Notes:   Read-back lags a write by the round trip of two handshakes.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Checksum enable bit 7 of the first register appends a CRC byte to reads.
// - Bits 6-5 select no, 0.12 or 0.2 percent per degree compensation.
// - Bits 4-2 select averaging of 1 to 32 samples for codes 0 to 5.
// - Conversion rate falls with averaging, for three axes and for one axis.
// - Bits 1-0 select standard, 16-bit-plus-status or 8-bit-plus-status read frames.
// - Threshold scheme 0 uses each signed axis limit as one threshold.
// - Scheme 1 uses the low seven bits as equal north and south thresholds.
// - Bit 4 of the second register selects low current or low noise.
// - Bit 3 clear keeps the bus glitch filter on; set turns it off.
// - Bit 2 starts conversions on bus command bits or on the interrupt pin.
// - A bus command during a running conversion waits until that conversion ends.
// - Triggers arriving while a triggered conversion is pending or running are ignored.
// - The trigger source counts only in standby, one conversion per trigger.
// - Bits 1-0 select standby, sleep, continuous or wake-up-and-sleep operation.
// - Leaving wake-up-and-sleep for standby rewrites the mode field to standby.
// - Both registers reset to zero at offsets 0 and 1, fully read-write.
// - The low power interval applies only in wake-up-and-sleep mode.
// - The limit direction is ignored when the threshold scheme exceeds one.
module sensor_mode_config_regs #(
  parameter int unsigned CYCLES_PER_MS = sensor_mode_cfg_pkg::CYCLES_PER_MS
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             link_clk,
  input  wire logic             link_resetn,
  input  wire logic             link_wr_valid,
  output logic                  link_wr_ready,
  input  wire logic [7:0]       link_addr,
  input  wire logic [7:0]       link_wdata,
  output logic      [7:0]       link_rd_data,
  input  wire logic             i2c_conv_cmd,
  input  wire logic             conv_done,
  input  wire logic             ws_exit_req,
  input  wire logic [3:0]       low_power_interval,
  input  wire logic             limit_direction,
  input  wire logic             single_axis,
  input  wire logic [2:0][7:0]  axis_limit_value,
  input  wire logic             irq_level,
  input  wire logic             int_pin_in,
  output logic                  int_pin_out,
  output logic                  int_pin_oe_n,
  output logic                  crc_append,
  output logic      [7:0]       temp_comp_x100,
  output logic      [2:0]       avg_code,
  output logic      [5:0]       samples_per_result,
  output logic      [7:0]       conv_rate_x10,
  output logic      [1:0]       read_frame,
  output logic                  threshold_signed,
  output logic                  threshold_symmetric,
  output logic                  direction_effective,
  output logic      [2:0][7:0]  upper_limit,
  output logic      [2:0][7:0]  lower_limit,
  output logic                  low_noise,
  output logic                  glitch_filter_en,
  output logic                  conv_start,
  output logic                  conv_busy,
  output logic      [1:0]       active_mode,
  output logic                  low_power_active
);
  typedef enum logic [1:0] {
    SEQ_IDLE      = 2'b00,
    SEQ_CONVERT   = 2'b01,
    SEQ_LOW_POWER = 2'b10
  } seq_t;

  typedef struct packed {
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    seq_t        seq;
    logic        trig_pending;
    logic        trig_running;
    logic        cmd_pending;
    logic        pin_prev;
    logic [2:0]  act_avg;
    logic [1:0]  act_mode;
    logic [7:0]  tempco;
    logic [1:0]  frame;
    logic        scheme_signed;
    logic        scheme_sym;
    logic        start;
    logic [31:0] sleep_cnt;
    logic [15:0] snap_last;
  } core_t;

  core_t       st_reg;
  core_t       st_next;
  logic        wr_valid;
  logic [15:0] wr_word;
  logic        snap_ready;
  logic        snap_send;
  logic        snap_valid;
  logic [15:0] snap_word;
  logic        pin_sync_q;
  logic        trig_edge;
  logic        trig_armed;
  logic [7:0]  rd_data_reg;

  word_handshake #(.W(16)) u_wr_cross (
    .src_clk    (link_clk),
    .src_resetn (link_resetn),
    .src_valid  (link_wr_valid),
    .src_ready  (link_wr_ready),
    .src_data   ({link_addr, link_wdata}),
    .dst_clk    (clk),
    .dst_resetn (resetn),
    .dst_valid  (wr_valid),
    .dst_data   (wr_word)
  );

  word_handshake #(.W(16)) u_snap_cross (
    .src_clk    (clk),
    .src_resetn (resetn),
    .src_valid  (snap_send),
    .src_ready  (snap_ready),
    .src_data   ({st_reg.cfg2, st_reg.cfg1}),
    .dst_clk    (link_clk),
    .dst_resetn (link_resetn),
    .dst_valid  (snap_valid),
    .dst_data   (snap_word)
  );

  pin_sync #(.W(1)) u_pin_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (int_pin_in),
    .sync_out (pin_sync_q)
  );

  assign snap_send  = snap_ready && ({st_reg.cfg2, st_reg.cfg1} != st_reg.snap_last);
  // The pin is a trigger input only while standby with pin triggering selected.
  assign trig_armed = (st_reg.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2]
                       == sensor_mode_cfg_pkg::MODE_STANDBY)
                      && st_reg.cfg2[sensor_mode_cfg_pkg::TRIG_BIT];
  assign trig_edge  = trig_armed && st_reg.pin_prev && !pin_sync_q;

  always_comb
  begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    st_next.pin_prev = pin_sync_q;
    if (snap_send)
    begin
      st_next.snap_last = {st_reg.cfg2, st_reg.cfg1};
    end
    if (wr_valid && (wr_word[15:8] == sensor_mode_cfg_pkg::CFG1_OFFSET))
    begin
      st_next.cfg1 = wr_word[7:0];
    end
    if (wr_valid && (wr_word[15:8] == sensor_mode_cfg_pkg::CFG2_OFFSET))
    begin
      st_next.cfg2 = wr_word[7:0];
    end
    // The device's own mode update runs after a host write in the same cycle, so it beats a write that keeps wake-up-and-sleep.
    if (ws_exit_req && (st_next.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2]
                        == sensor_mode_cfg_pkg::MODE_WAKE_SLEEP))
    begin
      st_next.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2] = sensor_mode_cfg_pkg::MODE_STANDBY;
    end
    unique case (st_next.cfg1[sensor_mode_cfg_pkg::TEMPCO_LSB +: 2])
      sensor_mode_cfg_pkg::TEMPCO_NONE: st_next.tempco = sensor_mode_cfg_pkg::COMP_NONE_X100;
      sensor_mode_cfg_pkg::TEMPCO_LOW:  st_next.tempco = sensor_mode_cfg_pkg::COMP_LOW_X100;
      sensor_mode_cfg_pkg::TEMPCO_HIGH: st_next.tempco = sensor_mode_cfg_pkg::COMP_HIGH_X100;
      default:                          st_next.tempco = st_reg.tempco;
    endcase
    if (st_next.cfg1[sensor_mode_cfg_pkg::FRAME_LSB +: 2] != sensor_mode_cfg_pkg::FRAME_RESERVED)
    begin
      st_next.frame = st_next.cfg1[sensor_mode_cfg_pkg::FRAME_LSB +: 2];
    end
    if (st_next.cfg2[sensor_mode_cfg_pkg::SCHEME_LSB +: 3] == sensor_mode_cfg_pkg::SCHEME_SIGNED)
    begin
      st_next.scheme_signed = 1'b1;
      st_next.scheme_sym    = 1'b0;
    end
    else if (st_next.cfg2[sensor_mode_cfg_pkg::SCHEME_LSB +: 3]
             == sensor_mode_cfg_pkg::SCHEME_SYMMETRIC)
    begin
      st_next.scheme_signed = 1'b0;
      st_next.scheme_sym    = 1'b1;
    end
    // Trigger and command requests are taken in standby only; triggers never stack, but one command may wait behind a running conversion.
    if (trig_edge && !st_reg.trig_pending && !st_reg.trig_running)
    begin
      st_next.trig_pending = 1'b1;
    end
    if (i2c_conv_cmd && !trig_armed && !st_reg.cmd_pending
        && (st_reg.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2] == sensor_mode_cfg_pkg::MODE_STANDBY))
    begin
      st_next.cmd_pending = 1'b1;
    end
    unique case (st_reg.seq)
      SEQ_IDLE:
      begin
        // No conversion is running, so a new mode applies at once.
        st_next.act_mode = st_reg.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2];
        if ((st_next.act_mode != sensor_mode_cfg_pkg::MODE_SLEEP)
            && ((st_next.act_mode != sensor_mode_cfg_pkg::MODE_STANDBY)
                || st_reg.trig_pending || st_reg.cmd_pending))
        begin
          st_next.start        = 1'b1;
          st_next.seq          = SEQ_CONVERT;
          st_next.act_avg      = st_reg.cfg1[sensor_mode_cfg_pkg::AVG_LSB +: 3];
          st_next.trig_running = st_reg.trig_pending;
          st_next.trig_pending = 1'b0;
          st_next.cmd_pending  = 1'b0;
        end
      end
      SEQ_CONVERT:
      begin
        if (conv_done)
        begin
          st_next.trig_running = 1'b0;
          if ((st_reg.act_mode == sensor_mode_cfg_pkg::MODE_WAKE_SLEEP)
              && (st_reg.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2]
                  == sensor_mode_cfg_pkg::MODE_WAKE_SLEEP))
          begin
            st_next.seq       = SEQ_LOW_POWER;
            st_next.sleep_cnt = 32'(sensor_mode_cfg_pkg::sleep_ms(low_power_interval)
                                    * CYCLES_PER_MS);
          end
          else
          begin
            st_next.seq = SEQ_IDLE;
          end
        end
      end
      SEQ_LOW_POWER:
      begin
        st_next.sleep_cnt = st_reg.sleep_cnt - 32'h0000_0001;
        if ((st_reg.sleep_cnt <= 32'h0000_0001)
            || (st_reg.cfg2[sensor_mode_cfg_pkg::MODE_LSB +: 2]
                != sensor_mode_cfg_pkg::MODE_WAKE_SLEEP))
        begin
          st_next.seq = SEQ_IDLE;
        end
      end
      default:
      begin
        st_next.seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg      <= '0;
      st_reg.cfg1 <= sensor_mode_cfg_pkg::CFG1_RESET;
      st_reg.cfg2 <= sensor_mode_cfg_pkg::CFG2_RESET;
      st_reg.seq  <= SEQ_IDLE;
      st_reg.pin_prev <= 1'b1;
      st_reg.scheme_signed <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Read-back is served from the mirrored copy, so bus reads never stall.
  always_ff @(posedge link_clk or negedge link_resetn)
  begin
    if (!link_resetn)
    begin
      rd_data_reg <= 8'h00;
    end
    else
    begin
      unique case (link_addr)
        sensor_mode_cfg_pkg::CFG1_OFFSET: rd_data_reg <= snap_valid ? snap_word[7:0] : rd_data_reg;
        sensor_mode_cfg_pkg::CFG2_OFFSET: rd_data_reg <= snap_valid ? snap_word[15:8]
                                                                    : rd_data_reg;
        default:                          rd_data_reg <= 8'h00;
      endcase
    end
  end

  logic [15:0] mirror_reg;
  always_ff @(posedge link_clk or negedge link_resetn)
  begin
    if (!link_resetn)
    begin
      mirror_reg <= {sensor_mode_cfg_pkg::CFG2_RESET, sensor_mode_cfg_pkg::CFG1_RESET};
    end
    else if (snap_valid)
    begin
      mirror_reg <= snap_word;
    end
  end

  assign link_rd_data = (link_addr == sensor_mode_cfg_pkg::CFG1_OFFSET) ? mirror_reg[7:0] :
                        (link_addr == sensor_mode_cfg_pkg::CFG2_OFFSET) ? mirror_reg[15:8] :
                        rd_data_reg;

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++)
    begin : g_axis
      assign upper_limit[ax] = st_reg.scheme_sym ? {1'b0, axis_limit_value[ax][6:0]}
                                                 : axis_limit_value[ax];
      assign lower_limit[ax] = st_reg.scheme_sym ? 8'(-{1'b0, axis_limit_value[ax][6:0]})
                                                 : axis_limit_value[ax];
    end
  endgenerate

  assign crc_append          = st_reg.cfg1[sensor_mode_cfg_pkg::CRC_BIT];
  assign temp_comp_x100      = st_reg.tempco;
  assign avg_code            = st_reg.act_avg;
  assign samples_per_result  = (st_reg.act_avg > sensor_mode_cfg_pkg::AVG_MAX_CODE) ? 6'h20
                               : 6'(6'h01 << st_reg.act_avg);
  assign conv_rate_x10       = sensor_mode_cfg_pkg::rate_x10(st_reg.act_avg, single_axis);
  assign read_frame          = st_reg.frame;
  assign threshold_signed    = st_reg.scheme_signed;
  assign threshold_symmetric = st_reg.scheme_sym;
  // Reserved schemes keep the old decode, so the raw field gates the direction.
  assign direction_effective = (st_reg.cfg2[sensor_mode_cfg_pkg::SCHEME_LSB +: 3]
                                <= sensor_mode_cfg_pkg::SCHEME_SYMMETRIC)
                               && limit_direction;
  assign low_noise           = st_reg.cfg2[sensor_mode_cfg_pkg::NOISE_BIT];
  assign glitch_filter_en    = !st_reg.cfg2[sensor_mode_cfg_pkg::GLITCH_BIT];
  assign conv_start          = st_reg.start;
  assign conv_busy           = (st_reg.seq == SEQ_CONVERT);
  assign active_mode         = st_reg.act_mode;
  assign low_power_active    = (st_reg.seq == SEQ_LOW_POWER);
  assign int_pin_out         = 1'b0;
  assign int_pin_oe_n        = trig_armed || !irq_level;

  property p_crc_write;
    @(posedge clk) disable iff (!resetn)
    wr_valid && (wr_word[15:8] == sensor_mode_cfg_pkg::CFG1_OFFSET)
      |=> crc_append == $past(wr_word[sensor_mode_cfg_pkg::CRC_BIT]);
  endproperty
  a_crc_write: assert property (p_crc_write) else $error("crc enable not stored");

  property p_tempco_high;
    @(posedge clk) disable iff (!resetn)
    wr_valid && (wr_word[15:8] == sensor_mode_cfg_pkg::CFG1_OFFSET)
      && (wr_word[6:5] == sensor_mode_cfg_pkg::TEMPCO_HIGH)
      |=> temp_comp_x100 == sensor_mode_cfg_pkg::COMP_HIGH_X100;
  endproperty
  a_tempco_high: assert property (p_tempco_high) else $error("tempco code 3 misdecoded");

  property p_avg_taken;
    @(posedge clk) disable iff (!resetn)
    conv_start |-> avg_code == $past(st_reg.cfg1[4:2]);
  endproperty
  a_avg_taken: assert property (p_avg_taken) else $error("averaging not taken at start");

  property p_avg_stable;
    @(posedge clk) disable iff (!resetn)
    conv_busy && $past(conv_busy) |-> $stable(avg_code);
  endproperty
  a_avg_stable: assert property (p_avg_stable) else $error("averaging changed mid conversion");

  property p_standby_cause;
    @(posedge clk) disable iff (!resetn)
    conv_start && (active_mode == sensor_mode_cfg_pkg::MODE_STANDBY)
      |-> $past(st_reg.trig_pending) || $past(st_reg.cmd_pending);
  endproperty
  a_standby_cause: assert property (p_standby_cause) else $error("standby start without cause");

  property p_no_start_busy;
    @(posedge clk) disable iff (!resetn)
    conv_busy && !conv_done |=> !conv_start;
  endproperty
  a_no_start_busy: assert property (p_no_start_busy) else $error("start during conversion");

  property p_no_stack;
    @(posedge clk) disable iff (!resetn)
    $rose(st_reg.trig_pending) |-> !$past(st_reg.trig_running);
  endproperty
  a_no_stack: assert property (p_no_stack) else $error("redundant trigger accepted");

  property p_ws_exit;
    @(posedge clk) disable iff (!resetn)
    ws_exit_req && !wr_valid && (st_reg.cfg2[1:0] == sensor_mode_cfg_pkg::MODE_WAKE_SLEEP)
      |=> st_reg.cfg2[1:0] == sensor_mode_cfg_pkg::MODE_STANDBY;
  endproperty
  a_ws_exit: assert property (p_ws_exit) else $error("mode field not updated on exit");

  property p_low_power_mode;
    @(posedge clk) disable iff (!resetn)
    low_power_active |-> active_mode == sensor_mode_cfg_pkg::MODE_WAKE_SLEEP;
  endproperty
  a_low_power_mode: assert property (p_low_power_mode) else $error("low power outside w&s");

  property p_sym_limits;
    @(posedge clk) disable iff (!resetn)
    threshold_symmetric |-> (upper_limit[0][7] == 1'b0)
      && (8'(upper_limit[0] + lower_limit[0]) == 8'h00);
  endproperty
  a_sym_limits: assert property (p_sym_limits) else $error("symmetric limits unequal");
endmodule : sensor_mode_config_regs
`default_nettype wire

/* src/sensor_mode_cfg_pkg.sv */
// Purpose: Shared constants and types of the sensor mode configuration block.
// Assumes: Byte-wide registers at small offsets; core clock of 20 MHz.
// Notes:   Decoding tables that several places need are functions here.
package sensor_mode_cfg_pkg;
  localparam logic [7:0] CFG1_OFFSET       = 8'h00;
  localparam logic [7:0] CFG2_OFFSET       = 8'h01;
  localparam logic [7:0] CFG1_RESET        = 8'h00;
  localparam logic [7:0] CFG2_RESET        = 8'h00;
  localparam int         CRC_BIT           = 7;
  localparam int         TEMPCO_LSB        = 5;
  localparam int         AVG_LSB           = 2;
  localparam int         FRAME_LSB         = 0;
  localparam int         SCHEME_LSB        = 5;
  localparam int         NOISE_BIT         = 4;
  localparam int         GLITCH_BIT        = 3;
  localparam int         TRIG_BIT          = 2;
  localparam int         MODE_LSB          = 0;
  localparam logic [1:0] TEMPCO_NONE       = 2'h0;
  localparam logic [1:0] TEMPCO_LOW        = 2'h1;
  localparam logic [1:0] TEMPCO_HIGH       = 2'h3;
  localparam logic [7:0] COMP_NONE_X100    = 8'h00;
  localparam logic [7:0] COMP_LOW_X100     = 8'h0c;
  localparam logic [7:0] COMP_HIGH_X100    = 8'h14;
  localparam logic [2:0] AVG_MAX_CODE      = 3'h5;
  localparam logic [1:0] FRAME_RESERVED    = 2'h3;
  localparam logic [2:0] SCHEME_SIGNED     = 3'h0;
  localparam logic [2:0] SCHEME_SYMMETRIC  = 3'h1;
  localparam int         CLK_HZ            = 20_000_000;
  localparam int         SLEEP_UNIT_MS     = 1;
  localparam int         CYCLES_PER_MS     = CLK_HZ / 1000 * SLEEP_UNIT_MS;

  typedef enum logic [1:0] {
    MODE_STANDBY    = 2'b00,
    MODE_SLEEP      = 2'b01,
    MODE_CONTINUOUS = 2'b10,
    MODE_WAKE_SLEEP = 2'b11
  } op_mode_t;

  // Low power interval in ms; codes Ch to Fh are undefined and take the longest time.
  function automatic logic [14:0] sleep_ms(input logic [3:0] code);
    logic [14:0] t;
    t = 15'h4e20;
    unique case (code)
      4'h0: t = 15'h0001;
      4'h1: t = 15'h0005;
      4'h2: t = 15'h000a;
      4'h3: t = 15'h000f;
      4'h4: t = 15'h0014;
      4'h5: t = 15'h001e;
      4'h6: t = 15'h0032;
      4'h7: t = 15'h0064;
      4'h8: t = 15'h01f4;
      4'h9: t = 15'h03e8;
      4'ha: t = 15'h07d0;
      4'hb: t = 15'h01f4;
      default: t = 15'h4e20;
    endcase
    return t;
  endfunction : sleep_ms

  // Conversion rate in tenths of kSPS for three axes or for one axis.
  function automatic logic [7:0] rate_x10(input logic [2:0] code, input logic one_axis);
    logic [7:0] r;
    r = 8'h04;
    unique case (code)
      3'h0: r = one_axis ? 8'hc8 : 8'h64;
      3'h1: r = one_axis ? 8'h85 : 8'h39;
      3'h2: r = one_axis ? 8'h50 : 8'h1f;
      3'h3: r = one_axis ? 8'h2c : 8'h10;
      3'h4: r = one_axis ? 8'h18 : 8'h08;
      default: r = one_axis ? 8'h0c : 8'h04;
    endcase
    return r;
  endfunction : rate_x10
endpackage : sensor_mode_cfg_pkg

/* src/pin_sync.sv */
// Purpose: Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes: Inputs are levels or pulses longer than two destination clocks.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pin_sync
`default_nettype wire

/* src/word_handshake.sv */
// Purpose: Carries one word at a time between two unrelated clock domains.
// Assumes: The source offers a word only while src_ready is high.
// Notes:   Toggle request with toggle acknowledge; the held word is stable while crossing.
`timescale 1ns/1ps
`default_nettype none
module word_handshake #(
  parameter int W = 16
) (
  input  wire logic         src_clk,
  input  wire logic         src_resetn,
  input  wire logic         src_valid,
  output logic              src_ready,
  input  wire logic [W-1:0] src_data,
  input  wire logic         dst_clk,
  input  wire logic         dst_resetn,
  output logic              dst_valid,
  output logic      [W-1:0] dst_data
);
  logic         req_reg;
  logic [W-1:0] hold_reg;
  logic [1:0]   ack_sync_reg;
  logic [1:0]   req_sync_reg;
  logic         seen_reg;
  logic         valid_reg;
  logic [W-1:0] data_reg;

  assign src_ready = (req_reg == ack_sync_reg[1]);

  always_ff @(posedge src_clk or negedge src_resetn)
  begin
    if (!src_resetn)
    begin
      req_reg      <= 1'b0;
      hold_reg     <= '0;
      ack_sync_reg <= 2'h0;
    end
    else
    begin
      ack_sync_reg <= {ack_sync_reg[0], seen_reg};
      if (src_valid && src_ready)
      begin
        req_reg  <= ~req_reg;
        hold_reg <= src_data;
      end
    end
  end

  always_ff @(posedge dst_clk or negedge dst_resetn)
  begin
    if (!dst_resetn)
    begin
      req_sync_reg <= 2'h0;
      seen_reg     <= 1'b0;
      valid_reg    <= 1'b0;
      data_reg     <= '0;
    end
    else
    begin
      req_sync_reg <= {req_sync_reg[0], req_reg};
      valid_reg    <= (req_sync_reg[1] != seen_reg);
      if (req_sync_reg[1] != seen_reg)
      begin
        seen_reg <= req_sync_reg[1];
        data_reg <= hold_reg;
      end
    end
  end

  assign dst_valid = valid_reg;
  assign dst_data  = data_reg;
endmodule : word_handshake
`default_nettype wire

/* testbench/host_model.sv */
// Purpose: Host controller model that writes and reads the configuration registers.
// Assumes: A write is held until ready is sampled high on a link clock edge.
// Notes:   Released write data is inverted so a stale byte never looks valid.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       link_clk,
  input  wire logic       link_wr_ready,
  input  wire logic [7:0] link_rd_data,
  output var  logic       link_wr_valid = 1'b0,
  output var  logic [7:0] link_addr = 8'h00,
  output var  logic [7:0] link_wdata = 8'h00
);
  // Callers hand over legal field codes only.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk);
    link_wr_valid <= 1'b1;
    link_addr     <= a;
    link_wdata    <= d;
    do @(posedge link_clk); while (link_wr_ready !== 1'b1);
    link_wr_valid <= 1'b0;
    link_wdata    <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge link_clk);
    link_addr <= a;
    repeat (2) @(posedge link_clk);
    d = link_rd_data;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

/* testbench/test_sensor_mode_config_regs.sv */
// Purpose: Self-checking bench for the configuration registers and sequencer.
// Assumes: Register traffic goes through the host model on the link clock.
// Notes:   Read-back is polled because the mirror lags each write.
`timescale 1ns/1ps
`default_nettype none
module test_sensor_mode_config_regs;
  logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, link_wr_valid, link_wr_ready;
  logic i2c_conv_cmd = 1'b0, conv_done = 1'b0, irq_level = 1'b0, int_pin_in = 1'b1;
  logic crc_append, threshold_signed, threshold_symmetric, low_noise, glitch_filter_en;
  logic conv_start, conv_busy;
  logic ws_exit_req = 1'b0, limit_direction = 1'b1, int_pin_oe_n, direction_effective;
  logic low_power_active;
  logic [1:0] active_mode;
  logic [7:0] link_addr, link_wdata, link_rd_data, temp_comp_x100, conv_rate_x10, rd;
  logic [2:0] avg_code;
  logic [5:0] samples_per_result;
  logic [1:0] read_frame;
  logic [2:0][7:0] axis_limit_value = {8'h00, 8'h00, 8'h85}, upper_limit, lower_limit;
  int n_errors = 0, check_count = 0, starts = 0;

  sensor_mode_config_regs #(.CYCLES_PER_MS(2)) sensor_mode_config_regs_i (
    .clk, .resetn, .link_clk, .link_resetn(resetn), .link_wr_valid, .link_wr_ready,
    .link_addr, .link_wdata, .link_rd_data, .i2c_conv_cmd, .conv_done,
    .ws_exit_req, .low_power_interval(4'h0), .limit_direction,
    .single_axis(1'b0), .axis_limit_value, .irq_level, .int_pin_in, .int_pin_out(),
    .int_pin_oe_n, .crc_append, .temp_comp_x100, .avg_code, .samples_per_result,
    .conv_rate_x10, .read_frame, .threshold_signed, .threshold_symmetric,
    .direction_effective, .upper_limit, .lower_limit, .low_noise,
    .glitch_filter_en, .conv_start, .conv_busy, .active_mode, .low_power_active);
  host_model host_model_i (
    .link_clk, .link_wr_ready, .link_rd_data, .link_wr_valid, .link_addr, .link_wdata);

  always #25 clk = ~clk;
  initial #3 forever #16 link_clk = ~link_clk;
  always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin n_errors++; $display("unexpected %s: expected %h seen %h", what, exp, seen); end
  endtask : check
  task automatic wr_back(input logic [7:0] a, input logic [7:0] d);
    host_model_i.write_reg(a, d);
    rd = ~d;
    for (int i = 0; i < 40 && rd !== d; i++) host_model_i.read_reg(a, rd);
    check("readback", rd, d);
  endtask : wr_back
  task automatic pulse_cmd();
    @(posedge clk) i2c_conv_cmd <= 1'b1;
    @(posedge clk) i2c_conv_cmd <= 1'b0;
  endtask : pulse_cmd
  task automatic pin_edge();
    @(posedge clk) int_pin_in <= 1'b0;
    repeat (4) @(posedge clk);
    int_pin_in <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : pin_edge
  task automatic wait_busy();
    for (int i = 0; i < 12 && conv_busy !== 1'b1; i++) @(posedge clk);
    check("busy", conv_busy, 1'b1);
  endtask : wait_busy
  // A second conversion held pending must start within the trailing wait.
  task automatic end_conv();
    @(posedge clk) conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : end_conv
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  initial
  begin
    #1_000_000;
    n_errors++;
    conclude();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    host_model_i.read_reg(8'h00, rd);
    check("cfg1 reset", rd, 8'h00);
    host_model_i.read_reg(8'h01, rd);
    check("cfg2 reset", rd, 8'h00);
    check("glitch reset", glitch_filter_en, 1'b1);
    check("signed reset", threshold_signed, 1'b1);
    wr_back(8'h00, 8'hf6);
    check("crc", crc_append, 1'b1);
    check("tempco", temp_comp_x100, 8'h14);
    check("frame", read_frame, 2'h2);
    wr_back(8'h01, 8'h38);
    check("symmetric", threshold_symmetric, 1'b1);
    check("upper", upper_limit[0], 8'h05);
    check("lower", lower_limit[0], 8'hfb);
    check("noise", low_noise, 1'b1);
    check("glitch", glitch_filter_en, 1'b0);
    host_model_i.write_reg(8'h05, 8'hff);
    host_model_i.read_reg(8'h05, rd);
    check("unmapped", rd, 8'h00);
    pulse_cmd();
    wait_busy();
    pulse_cmd();
    end_conv();
    wait_busy();
    end_conv();
    check("starts", 8'(starts), 8'h02);
    check("avg", avg_code, 3'h5);
    check("samples", samples_per_result, 6'h20);
    check("rate", conv_rate_x10, 8'h04);
    wr_back(8'h01, 8'h3c);
    pulse_cmd();
    pin_edge();
    wait_busy();
    pin_edge();
    end_conv();
    check("starts", 8'(starts), 8'h03);
    check("idle", conv_busy, 1'b0);
    @(posedge clk) irq_level <= 1'b1;
    @(posedge clk) check("pin released", int_pin_oe_n, 1'b1);
    wr_back(8'h01, 8'h03);
    check("pin driven", int_pin_oe_n, 1'b0);
    check("w&s mode", active_mode, 2'h3);
    check("direction", direction_effective, 1'b1);
    wait_busy();
    @(posedge clk) conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
    @(posedge clk) check("low power", low_power_active, 1'b1);
    wait_busy();
    @(posedge clk) ws_exit_req <= 1'b1;
    @(posedge clk) ws_exit_req <= 1'b0;
    repeat (20) @(posedge clk);
    host_model_i.read_reg(8'h01, rd);
    check("mode exit", rd, 8'h00);
    end_conv();
    check("standby", active_mode, 2'h0);
    check("stopped", conv_busy, 1'b0);
    conclude();
  end
endmodule : test_sensor_mode_config_regs
`default_nettype wire
